// File: src/asff_pkg.sv
package asff_pkg;

  typedef enum logic [1:0] {
    ASFF_WL16,
    ASFF_WL24,
    ASFF_WL32
  } asff_wlen_e;

  // one configuration word: frame mode and check-word enable
  typedef struct packed {
    logic fixed_frame;
    logic crc_enable;
  } asff_cfg_s;

  // word_length_strap pad: float flag above level
  typedef struct packed {
    logic floating;
    logic level;
  } asff_strap_s;

  localparam int unsigned NUM_CHANNELS = 4;
  localparam int unsigned RESULT_BITS = 24;
  localparam int unsigned HALF_BITS = 16;

  typedef logic [NUM_CHANNELS-1:0][RESULT_BITS-1:0] asff_results_t;

  localparam asff_cfg_s CFG_RESET = '{fixed_frame: 1'b0, crc_enable: 1'b0};
  localparam asff_wlen_e WLEN_RESET = ASFF_WL16;

  localparam logic [4:0] LAST_BIT_16 = 5'h0f;
  localparam logic [4:0] LAST_BIT_24 = 5'h17;
  localparam logic [4:0] LAST_BIT_32 = 5'h1f;
  localparam logic [4:0] CMD_LAST_BIT = 5'h0f;

  localparam logic [2:0] WORDS_FIXED = 3'h6;
  localparam logic [2:0] WORDS_ACTIVE_NO_CRC = 3'h5;
  localparam logic [2:0] WORDS_STANDBY = 3'h1;
  localparam logic [2:0] WORDS_STANDBY_CRC = 3'h2;
  localparam logic [2:0] WORD_STATUS = 3'h0;
  localparam logic [2:0] WORD_FIRST_CHANNEL = 3'h1;
  localparam logic [2:0] WORD_LAST_CHANNEL = 3'h4;
  localparam logic [2:0] WORD_INDEX_MAX = 3'h6;

  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam logic CS_IDLE = 1'b1;

endpackage

// File: src/asff_sync.sv
`timescale 1ns/1ps
module asff_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clock, // destination clock
  input wire logic rst, // async reset, active high
  input wire logic clock_enable, // freezes the stages while low
  input wire logic [WIDTH-1:0] async_in, // from another domain or a pin
  output logic [WIDTH-1:0] sync_out // safe to use in the clock domain
);

  logic [WIDTH-1:0] stage1;

  // stage1 feeds nothing but the second stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1 <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else if (clock_enable) begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// File: src/asff_frame_formatter.sv
`timescale 1ns/1ps
// Operation
// - frame opens when chip select falls
// - receive and transmit in the same frame
// - strap sampled once after reset, then held
// - strap high gives 32, low gives 24
// - floating strap gives 16, low byte dropped
// - frame-mode bit, dynamic after reset
// - fixed mode: status, four channels, check word (zeros when check is off)
// - standby dynamic: one word, two with check
// - powered dynamic: five words, six with check
// - status word always goes first
// - status is sixteen bits, lower bits zero
// - one word per channel, 24-bit results
// - truncate to 16 in 16-bit or coded 24
// - 32-bit uncoded appends eight zero bits
// - two's complement, most significant bit first
// - 16-bit codes clip at 7fff and 8000
// - check word enabled, sits in top bits
// - coded words carry data plus code byte; the code byte is sent as zero here
module asff_frame_formatter
  import asff_pkg::*;
(
  input wire logic clock, // system clock, 125 MHz
  input wire logic rst, // async reset, active high
  input wire logic clock_enable, // system-domain state frozen while low
  input wire asff_strap_s word_length_strap, // word length pad state
  input wire logic error_correction_strap, // code byte in words when high
  input wire logic config_load, // take digital_system_config this cycle
  input wire asff_cfg_s digital_system_config, // frame mode and check enable
  input wire logic adcs_powered, // channels converting, not standby
  input wire logic [HALF_BITS-1:0] status_word, // monitor status or reply
  input wire asff_results_t conversion, // clipped 24-bit channel results
  input wire logic [HALF_BITS-1:0] crc_word, // check value for the frame
  input wire logic sclk, // serial clock from the host
  input wire logic cs_n, // chip select, active low
  input wire logic din, // serial data in
  output logic dout, // serial data out
  output logic dout_enable, // high while dout is driven
  output logic frame_busy, // a frame is open
  output logic [HALF_BITS-1:0] cmd_word, // last host command
  output logic cmd_valid, // one-cycle pulse with cmd_word
  output asff_wlen_e word_length // latched word length
);

  // ---------------- system domain ----------------

  asff_strap_s strap_sync;
  logic hamming_sync;
  logic [1:0] strap_wait;
  logic strap_taken;
  logic hamming_on;
  asff_cfg_s cfg;
  asff_cfg_s frame_cfg;
  logic [HALF_BITS-1:0] frame_status;
  logic [HALF_BITS-1:0] frame_crc;
  logic cs_sync;
  logic toggle_sync;
  logic toggle_seen;

  // link-domain signals, plus the frame-image flops the link reads
  logic link_rst;
  logic [4:0] bit_cnt;
  logic [2:0] word_idx;
  logic [4:0] rx_cnt;
  logic [HALF_BITS-1:0] rx_shift;
  logic [HALF_BITS-1:0] rx_cmd;
  logic cmd_toggle;
  logic [31:0] tx_word;
  logic [NUM_CHANNELS-1:0][31:0] frame_channel;
  logic [2:0] frame_words;
  logic [4:0] last_bit;

  asff_sync #(
    .WIDTH(3),
    .RESET_VALUE(3'h0)
  ) u_strap_sync (
    .clock(clock),
    .rst(rst),
    .clock_enable(clock_enable),
    .async_in({word_length_strap, error_correction_strap}),
    .sync_out({strap_sync, hamming_sync})
  );

  asff_sync #(
    .WIDTH(2),
    .RESET_VALUE({CS_IDLE, 1'b0})
  ) u_link_sync (
    .clock(clock),
    .rst(rst),
    .clock_enable(clock_enable),
    .async_in({cs_n, cmd_toggle}),
    .sync_out({cs_sync, toggle_sync})
  );

  // straps are caught once, after the synchroniser has filled
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strap_wait <= 2'h0;
      strap_taken <= 1'b0;
      word_length <= WLEN_RESET;
      hamming_on <= 1'b0;
    end else if (clock_enable && !strap_taken) begin
      if (strap_wait != STRAP_SETTLE) begin
        strap_wait <= strap_wait + 2'h1;
      end else begin
        strap_taken <= 1'b1;
        hamming_on <= hamming_sync;
        if (strap_sync.floating) begin
          word_length <= ASFF_WL16;
        end else if (strap_sync.level) begin
          word_length <= ASFF_WL32;
        end else begin
          word_length <= ASFF_WL24;
        end
      end
    end
  end

  // configuration resets to dynamic frames with no check word
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg <= CFG_RESET;
    end else if (clock_enable && config_load) begin
      cfg <= digital_system_config;
    end
  end

  // frame image follows its sources only while idle, so the link
  // reads values that stand still for the whole frame; a change made
  // mid-frame shows in the next frame
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frame_cfg <= CFG_RESET;
      frame_status <= '0;
      frame_crc <= '0;
    end else if (clock_enable && cs_sync) begin
      frame_cfg <= cfg;
      frame_status <= status_word;
      frame_crc <= crc_word;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frame_busy <= 1'b0;
    end else if (clock_enable) begin
      frame_busy <= ~cs_sync;
    end
  end

  // rx_cmd holds still until the next frame's sixteenth bit, so only
  // the toggle needs synchronising, not the sixteen data bits
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      toggle_seen <= 1'b0;
      cmd_word <= '0;
      cmd_valid <= 1'b0;
    end else if (clock_enable) begin
      toggle_seen <= toggle_sync;
      cmd_valid <= toggle_sync ^ toggle_seen;
      if (toggle_sync ^ toggle_seen) begin
        cmd_word <= rx_cmd;
      end
    end
  end

  // ---------------- link domain ----------------

  function automatic logic [4:0] word_last_bit(input asff_wlen_e wl);
    unique case (wl)
      ASFF_WL16: word_last_bit = LAST_BIT_16;
      ASFF_WL24: word_last_bit = LAST_BIT_24;
      ASFF_WL32: word_last_bit = LAST_BIT_32;
      default: word_last_bit = LAST_BIT_16;
    endcase
  endfunction

  function automatic logic [2:0] words_per_frame(input asff_cfg_s c, input logic adc_on);
    if (c.fixed_frame) begin
      words_per_frame = WORDS_FIXED;
    end else if (!adc_on) begin
      words_per_frame = c.crc_enable ? WORDS_STANDBY_CRC : WORDS_STANDBY;
    end else begin
      words_per_frame = c.crc_enable ? WORDS_FIXED : WORDS_ACTIVE_NO_CRC;
    end
  endfunction

  // words are left-justified in 32 bits; only the top word length is sent
  function automatic logic [31:0] channel_word(input logic [RESULT_BITS-1:0] r,
                                               input asff_wlen_e wl, input logic ham);
    // results arrive already clipped, so the top half clips at 7fff/8000
    if (wl == ASFF_WL16 || (wl == ASFF_WL24 && ham)) begin
      channel_word = {r[RESULT_BITS-1 -: HALF_BITS], 16'h0000};
    end else begin
      // code byte, when present, is left zero here
      channel_word = {r, 8'h00};
    end
  endfunction

  // cs_n high clears the link at once; a cut frame leaves nothing behind
  assign link_rst = rst | cs_n;

  // word count and word length are frame-image flops as well: the link
  // never decodes system-domain signals combinationally
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frame_words <= WORDS_STANDBY;
      last_bit <= LAST_BIT_16;
    end else if (clock_enable && cs_sync) begin
      frame_words <= words_per_frame(cfg, adcs_powered);
      last_bit <= word_last_bit(word_length);
    end
  end

  // truncation and padding happen while idle, so at each sclk edge the
  // link picks a finished word instead of decoding across the boundary
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frame_channel <= '0;
    end else if (clock_enable && cs_sync) begin
      for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
        frame_channel[ch] <= channel_word(conversion[ch], word_length, hamming_on);
      end
    end
  end

  always_comb begin
    tx_word = 32'h0000_0000;
    if (word_idx == WORD_STATUS) begin
      tx_word = {frame_status, 16'h0000};
    end else if (word_idx == frame_words - 3'h1 && frame_cfg.crc_enable) begin
      tx_word = {frame_crc, 16'h0000};
    end else if (word_idx < frame_words && word_idx >= WORD_FIRST_CHANNEL
                 && word_idx <= WORD_LAST_CHANNEL) begin
      tx_word = frame_channel[word_idx - WORD_FIRST_CHANNEL];
    end
  end

  // word and bit position; chip select high clears them
  // index parks at six so an overlong frame never wraps onto status
  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt <= 5'h00;
      word_idx <= WORD_STATUS;
    end else if (bit_cnt == last_bit) begin
      bit_cnt <= 5'h00;
      if (word_idx != WORD_INDEX_MAX) begin
        word_idx <= word_idx + 3'h1;
      end
    end else begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // device launches on the rising edge, host samples on the falling
  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      dout <= 1'b0;
    end else begin
      dout <= tx_word[5'h1f - bit_cnt];
    end
  end

  // the pin counts as driven from the first rising sclk of a frame
  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      dout_enable <= 1'b0;
    end else begin
      dout_enable <= 1'b1;
    end
  end

  // receive side of the same frame
  // counter parks at sixteen: later din bits are ignored
  always_ff @(negedge sclk or posedge link_rst) begin
    if (link_rst) begin
      rx_cnt <= 5'h00;
      rx_shift <= '0;
    end else if (rx_cnt <= CMD_LAST_BIT) begin
      rx_cnt <= rx_cnt + 5'h01;
      rx_shift <= {rx_shift[HALF_BITS-2:0], din};
    end
  end

  // only the top sixteen bits of the first word are kept
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      rx_cmd <= '0;
      cmd_toggle <= 1'b0;
    end else if (!cs_n && rx_cnt == CMD_LAST_BIT) begin
      rx_cmd <= {rx_shift[HALF_BITS-2:0], din};
      cmd_toggle <= ~cmd_toggle;
    end
  end

endmodule

// File: sim/asff_host_model.sv
`timescale 1ns/1ps
module asff_host_model (
  output logic sclk, // serial clock, still between frames
  output logic cs_n, // chip select, active low
  output logic din, // serial data to the device
  input wire logic dout // serial data from the device
);
  localparam realtime HALF = 62.5;
  // off the system clock grid, so the two clocks keep no fixed phase
  localparam realtime LEAD = 100.3;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // launch on rising sclk, take dout on falling sclk
  task automatic xfer(input int nbits, input logic [15:0] cmd, output logic [255:0] rx);
    rx = '0;
    cs_n = 1'b0;
    #LEAD;
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b1;
      din = (i < 16) ? cmd[15 - i] : 1'b0;
      #HALF;
      sclk = 1'b0;
      rx = {rx[254:0], dout};
      #HALF;
    end
    cs_n = 1'b1;
    // released line: no pull, so show the inverse rather than the last bit
    din = ~din;
    #100;
  endtask
endmodule

// File: sim/asff_frame_formatter_assertions.sv
`timescale 1ns/1ps
module asff_frame_formatter_checker
  import asff_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic rst, // async reset
  input wire asff_strap_s word_length_strap, // strap pad
  input wire logic cs_n, // chip select
  input wire logic dout, // serial out
  input wire logic dout_enable, // serial out driven
  input wire logic frame_busy, // frame open
  input wire logic [HALF_BITS-1:0] cmd_word, // last command
  input wire logic cmd_valid, // command pulse
  input wire asff_wlen_e word_length // latched length
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [3:0] since_rst;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) since_rst <= 4'h0;
    else if (since_rst != 4'hf) since_rst <= since_rst + 4'h1;
  end
  property p_cs_idle; cs_n && $past(cs_n) |-> !dout && !dout_enable; endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("link driven while deselected");
  property p_busy_rise; $fell(cs_n) |-> ##[1:4] frame_busy; endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("frame start not seen");
  property p_busy_fall; $rose(cs_n) |-> ##[1:4] !frame_busy; endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("frame end not seen");
  property p_busy_cs; $fell(frame_busy) |-> cs_n && $past(cs_n, 2); endproperty
  a_busy_cs: assert property (p_busy_cs) else $error("frame closed without deselect");
  property p_en_frame; dout_enable |-> !cs_n; endproperty
  a_en_frame: assert property (p_en_frame) else $error("serial out driven outside frame");
  property p_cmd_pulse; cmd_valid |=> !cmd_valid; endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("command pulse too long");
  property p_cmd_hold; $changed(cmd_word) |-> cmd_valid; endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command moved without pulse");
  property p_cmd_in_frame; cmd_valid |-> !cs_n && frame_busy; endproperty
  a_cmd_in_frame: assert property (p_cmd_in_frame) else $error("command outside frame");
  property p_wl_hold; since_rst > 4'h8 |-> $stable(word_length); endproperty
  a_wl_hold: assert property (p_wl_hold) else $error("word length moved");
  property p_wl_decode;
    since_rst == 4'h7 |-> word_length == (word_length_strap.floating ? ASFF_WL16 :
      word_length_strap.level ? ASFF_WL32 : ASFF_WL24);
  endproperty
  a_wl_decode: assert property (p_wl_decode) else $error("word length decode wrong");
endmodule
bind asff_frame_formatter asff_frame_formatter_checker chk (.clock, .rst, .word_length_strap, .cs_n, .dout,
  .dout_enable, .frame_busy, .cmd_word, .cmd_valid, .word_length);

// File: sim/test_adc_spi_frame_formatter.sv
`timescale 1ns/1ps
module test_adc_spi_frame_formatter;
  import asff_pkg::*;
  logic clock = 1'b0, rst = 1'b1, clock_enable = 1'b1, error_correction_strap = 1'b0;
  logic config_load = 1'b0, adcs_powered = 1'b0;
  logic sclk, cs_n, din, dout, dout_enable, frame_busy, cmd_valid;
  asff_strap_s word_length_strap = 2'h2;
  asff_cfg_s digital_system_config = CFG_RESET;
  logic [15:0] status_word = 16'ha5c3, crc_word = 16'h3c5a, cmd_word;
  // clip codes on purpose: truncation must give 7fff, 8000, 0000, ffff
  asff_results_t conversion = {24'h7fffff, 24'h800000, 24'h000000, 24'hffffff};
  asff_wlen_e word_length, wl_exp;
  int n_errors = 0, checks_done = 0, n_pulses = 0;
  always @(negedge clock) if (cmd_valid === 1'b1) n_pulses++;
  logic [255:0] rx;
  logic [2:0] cases [6] = '{3'h0, 3'h2, 3'h1, 3'h3, 3'h4, 3'h6}; // fixed, crc, powered
  always #4 clock = ~clock;
  asff_frame_formatter dut (.clock, .rst, .clock_enable, .word_length_strap, .error_correction_strap,
    .config_load, .digital_system_config, .adcs_powered, .status_word, .conversion, .crc_word, .sclk,
    .cs_n, .din, .dout, .dout_enable, .frame_busy, .cmd_word, .cmd_valid, .word_length);
  asff_host_model host (.sclk, .cs_n, .din, .dout);
  function automatic logic [255:0] expect_frame(int l, int nw, logic ham, logic crc);
    logic [31:0] w;
    logic [255:0] r;
    r = '0;
    for (int i = 0; i <= nw; i++) begin
      if (crc && i == nw - 1) w = {crc_word, 16'h0};
      else if (i == 0) w = {status_word, 16'h0};
      else if (i < nw && i < 5)
        w = (l == 16 || ham) ? {conversion[i-1][23:8], 16'h0} : {conversion[i-1], 8'h0};
      else w = '0;
      r = (r << l) | 256'(w >> (32 - l));
    end
    return r;
  endfunction
  task automatic chk_frame(input logic [255:0] got, input logic [255:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t frame %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    int l, nw;
    logic [2:0] c3;
    logic [15:0] cmd;
    for (int s = 0; s < 4; s++) begin
      @(negedge clock);
      rst = 1'b1;
      word_length_strap = (s == 0) ? 2'h2 : (s == 1) ? 2'h1 : 2'h0;
      error_correction_strap = (s == 3);
      repeat (12) @(negedge clock);
      rst = 1'b0;
      repeat (8) @(negedge clock);
      l = (s == 0) ? 16 : (s == 1) ? 32 : 24;
      wl_exp = (s == 0) ? ASFF_WL16 : (s == 1) ? ASFF_WL32 : ASFF_WL24;
      chk_val({14'h0, word_length}, {14'h0, wl_exp});
      word_length_strap = ~word_length_strap;
      host.xfer(8, 16'hffff, rx); // frame cut before the command completes
      chk_frame(rx, 256'(status_word[15:8]));
      chk_val(cmd_word, 16'h0000);
      for (int c = 0; c < 6; c++) begin
        @(negedge clock);
        c3 = cases[c];
        digital_system_config = '{fixed_frame: c3[2], crc_enable: c3[1]};
        adcs_powered = c3[0];
        config_load = (c != 0); // first frame runs on the reset config
        @(negedge clock);
        config_load = 1'b0;
        repeat (4) @(negedge clock);
        nw = c3[2] ? 6 : c3[0] ? (c3[1] ? 6 : 5) : (c3[1] ? 2 : 1);
        cmd = 16'h1000 + 16'(s * 16 + c);
        host.xfer((nw + 1) * l, cmd, rx);
        chk_frame(rx, expect_frame(l, nw, s == 3, c3[1]));
        chk_val(cmd_word, cmd);
        chk_val(16'(n_pulses), 16'(s * 6 + c + 1));
        chk_val({14'h0, frame_busy, dout_enable}, 16'h0000);
      end
      chk_val({14'h0, word_length}, {14'h0, wl_exp});
      $display("strap setting %0d done", s);
    end
    give_verdict();
  end
  // run needs about 0.4 ms; 0.7 ms means a hang
  initial begin
    #700us;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule
